// *** pkg/iopc_pkg.sv ***
// Package: register map, field positions and reset values of the port block
package iopc_pkg;
	// ------------------------------------------------------------
	// Register word offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_PORT_A  = 8'h00;
	localparam logic [7:0] OFF_PORT_B  = 8'h04;
	localparam logic [7:0] OFF_DIR_B   = 8'h08;
	localparam logic [7:0] OFF_PORT_C  = 8'h0c;
	localparam logic [7:0] OFF_DIR_C   = 8'h10;
	localparam logic [7:0] OFF_PORT_D  = 8'h14;
	localparam logic [7:0] OFF_DIR_D   = 8'h18;
	localparam logic [7:0] OFF_PORT_E  = 8'h1c;
	localparam logic [7:0] OFF_DIR_E   = 8'h20;
	localparam logic [7:0] OFF_PULLUP  = 8'h24;
	localparam logic [7:0] OFF_CHG_EN  = 8'h28;
	localparam logic [7:0] OFF_CTRL    = 8'h2c;
	localparam logic [7:0] OFF_STATUS  = 8'h30;
	localparam logic [7:0] OFF_MASK    = 8'h34;
	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;   // 2-bit processor mode
	localparam int CTRL_PWM1_ON  = 2;
	localparam int CTRL_PWM2_ON  = 3;
	localparam int CTRL_SER_ON   = 4;
	localparam int CTRL_WIDTH    = 5;
	// Status / mask fields
	localparam int ST_CHANGE     = 0;
	localparam int ST_WIDTH      = 1;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DIR      = 8'hff;
	localparam logic [7:0] RST_LATCH    = 8'h00;
	localparam logic [1:0] RST_OD_LATCH = 2'h3;
	localparam logic [CTRL_WIDTH-1:0] RST_CTRL = 5'h00;
	// ------------------------------------------------------------
	// Processor modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		IOPC_MODE_MPU      = 2'b00,
		IOPC_MODE_EXT_MCU  = 2'b01,
		IOPC_MODE_MCU      = 2'b10,
		IOPC_MODE_MCU_PROT = 2'b11
	} iopc_mode_t;
endpackage : iopc_pkg

// *** logic/iopc_top.sv ***
// Port pin control block: ports A to E with Wishbone register access
`timescale 1ns/1ps
// What this block does
// - Ports B to E each have a per-pin direction register.
// - Ports C, D, E become system bus in MPU and extended MCU modes.
// - Enabling pulse-width or serial unit takes its pins automatically.
// - Direction bits of forced pins keep their written value; software rewrites after disable.
// - Peripheral input pin set as output sees the port's own driven value.
// - Port A is six pins without direction, latched only on pins 2 and 3; reads return pin levels.
// - Port A pin 1 is timer 0 clock; pins 4, 5 serial, serial-controlled.
// - Port A pins 2, 3 open drain: 0 drives low, 1 releases.
// - Writes to port A change only pins 2 and 3.
// - Direction bit clear makes output, set makes input (0xcf example).
// - Port B bits 0,1 capture inputs; bits 2,3 pulse-width outputs.
// - Port B bit 4 clocks timers 1 and 2; bit 5 clocks timer 3.
// - Port B pins: Schmitt input, enabled pull-up, enabled change interrupt.
module iopc_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o,
	// Port A pins
	input  wire logic [5:0]  port_a_i,
	output logic      [5:0]  port_a_o,
	output logic      [5:0]  port_a_oe_o,
	// Port B pins (Schmitt conditioned in the pad)
	input  wire logic [7:0]  port_b_i,
	output logic      [7:0]  port_b_o,
	output logic      [7:0]  port_b_oe_o,
	output logic      [7:0]  port_b_pullup_o,
	// Ports C, D, E pins
	input  wire logic [7:0]  port_c_i,
	output logic      [7:0]  port_c_o,
	output logic      [7:0]  port_c_oe_o,
	input  wire logic [7:0]  port_d_i,
	output logic      [7:0]  port_d_o,
	output logic      [7:0]  port_d_oe_o,
	input  wire logic [7:0]  port_e_i,
	output logic      [7:0]  port_e_o,
	output logic      [7:0]  port_e_oe_o,
	// Processor mode (configuration bits)
	output logic             sys_bus_mode_o,
	// System bus side for ports C, D, E
	input  wire logic [7:0]  bus_c_out_i,
	input  wire logic [7:0]  bus_c_oe_i,
	input  wire logic [7:0]  bus_d_out_i,
	input  wire logic [7:0]  bus_d_oe_i,
	input  wire logic [7:0]  bus_e_out_i,
	input  wire logic [7:0]  bus_e_oe_i,
	// Peripheral side
	input  wire logic        pwm1_i,
	input  wire logic        pwm2_i,
	input  wire logic        ser_a_out_i,
	input  wire logic        ser_a_oe_i,
	input  wire logic        ser_b_out_i,
	input  wire logic        ser_b_oe_i,
	output logic             timer0_clock_pin_o,
	output logic             capture1_o,
	output logic             capture2_o,
	output logic             timer12_clock_pin_o,
	output logic             timer3_clock_pin_o,
	output logic      [1:0]  serial_in_o
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Port A open-drain bits, ports B to E data and direction
	logic [1:0]                       od_latch;   // Pins 2 and 3 of port A
	logic [7:0]                       second_port_latch;
	logic [7:0]                       second_port_direction;
	logic [7:0]                       third_port_latch;
	logic [7:0]                       third_port_direction;
	logic [7:0]                       fourth_port_latch;
	logic [7:0]                       fourth_port_direction;
	logic [7:0]                       fifth_port_latch;
	logic [7:0]                       fifth_port_direction;
	// Software set-up of pull-ups, change detect, mode and irq
	logic [7:0]                       pullup_en;
	logic [7:0]                       change_en;
	logic [iopc_pkg::CTRL_WIDTH-1:0]  ctrl;
	logic [iopc_pkg::ST_WIDTH-1:0]    status;
	logic [iopc_pkg::ST_WIDTH-1:0]    mask;
	// Change detector state
	logic [7:0]                       change_ref;  // Last latched B levels

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr == off);
	endfunction : hit

	// Taken once: ack blocks a second take in its own cycle
	wire       req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Every register sits in byte lane 0; other lanes are ignored
	wire       wr        = req && wb_we_i && wb_sel_i[0];
	wire [7:0] wd        = wb_dat_i[7:0];
	wire       wr_port_a = wr && hit(wb_adr_i, iopc_pkg::OFF_PORT_A);
	wire       wr_port_b = wr && hit(wb_adr_i, iopc_pkg::OFF_PORT_B);
	wire       wr_dir_b  = wr && hit(wb_adr_i, iopc_pkg::OFF_DIR_B);
	wire       wr_port_c = wr && hit(wb_adr_i, iopc_pkg::OFF_PORT_C);
	wire       wr_dir_c  = wr && hit(wb_adr_i, iopc_pkg::OFF_DIR_C);
	wire       wr_port_d = wr && hit(wb_adr_i, iopc_pkg::OFF_PORT_D);
	wire       wr_dir_d  = wr && hit(wb_adr_i, iopc_pkg::OFF_DIR_D);
	wire       wr_port_e = wr && hit(wb_adr_i, iopc_pkg::OFF_PORT_E);
	wire       wr_dir_e  = wr && hit(wb_adr_i, iopc_pkg::OFF_DIR_E);
	wire       wr_pullup = wr && hit(wb_adr_i, iopc_pkg::OFF_PULLUP);
	wire       wr_chg_en = wr && hit(wb_adr_i, iopc_pkg::OFF_CHG_EN);
	wire       wr_ctrl   = wr && hit(wb_adr_i, iopc_pkg::OFF_CTRL);
	wire       wr_status = wr && hit(wb_adr_i, iopc_pkg::OFF_STATUS);
	wire       wr_mask   = wr && hit(wb_adr_i, iopc_pkg::OFF_MASK);

	// ------------------------------------------------------------
	// Pin ownership
	// ------------------------------------------------------------
	// MPU and extended MCU modes hand C, D, E to the system bus
	wire       bus_mode = (ctrl[1:0] == iopc_pkg::IOPC_MODE_MPU) ||
	                      (ctrl[1:0] == iopc_pkg::IOPC_MODE_EXT_MCU);
	wire       pwm1_on  = ctrl[iopc_pkg::CTRL_PWM1_ON];
	wire       pwm2_on  = ctrl[iopc_pkg::CTRL_PWM2_ON];
	wire       ser_on   = ctrl[iopc_pkg::CTRL_SER_ON];
	// Direction bit clear means output
	wire [7:0] b_gpio_oe = ~second_port_direction;
	// Peripherals override without touching the direction bits
	wire [7:0] next_b_oe = {b_gpio_oe[7:4],
	                        pwm2_on | b_gpio_oe[3],
	                        pwm1_on | b_gpio_oe[2],
	                        b_gpio_oe[1:0]};
	wire [7:0] next_b_out = {second_port_latch[7:4],
	                         pwm2_on ? pwm2_i : second_port_latch[3],
	                         pwm1_on ? pwm1_i : second_port_latch[2],
	                         second_port_latch[1:0]};
	// Output pins read back what the port drives, so peripherals see it
	wire [7:0] b_level = (next_b_oe & next_b_out) |
	                     (~next_b_oe & port_b_i);
	wire [5:0] a_level = (port_a_oe_o & port_a_o) | (~port_a_oe_o & port_a_i);
	// Same owner choice for all three ports: system bus or own register
	function automatic logic [7:0] owner(input logic       by_sys,
	                                     input logic [7:0] by_bus,
	                                     input logic [7:0] by_port);
		owner = by_sys ? by_bus : by_port;
	endfunction : owner

	wire [7:0] c_oe  = owner(bus_mode, bus_c_oe_i,
	                         ~third_port_direction);
	wire [7:0] d_oe  = owner(bus_mode, bus_d_oe_i,
	                         ~fourth_port_direction);
	wire [7:0] e_oe  = owner(bus_mode, bus_e_oe_i,
	                         ~fifth_port_direction);
	wire [7:0] c_out = owner(bus_mode, bus_c_out_i, third_port_latch);
	wire [7:0] d_out = owner(bus_mode, bus_d_out_i, fourth_port_latch);
	wire [7:0] e_out = owner(bus_mode, bus_e_out_i, fifth_port_latch);
	// Change detection on input-configured pins only
	wire [7:0] b_diff   = (port_b_i ^ change_ref) & second_port_direction &
	                      change_en;
	wire       chg_evt  = |b_diff;
	// Flag stays up until software writes a one to it
	wire [iopc_pkg::ST_WIDTH-1:0] next_status =
	    (status & ~(wr_status ? wd[iopc_pkg::ST_WIDTH-1:0] : 1'b0)) |
	    chg_evt; // Set wins over clear

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	// A and B read resolved levels, C to E raw pins, holes read zero
	logic [7:0] rd;
	always_comb begin
		case (wb_adr_i)
			iopc_pkg::OFF_PORT_A: rd = {2'h0, a_level};
			iopc_pkg::OFF_PORT_B: rd = b_level;
			iopc_pkg::OFF_DIR_B:  rd = second_port_direction;
			iopc_pkg::OFF_PORT_C: rd = port_c_i;
			iopc_pkg::OFF_DIR_C:  rd = third_port_direction;
			iopc_pkg::OFF_PORT_D: rd = port_d_i;
			iopc_pkg::OFF_DIR_D:  rd = fourth_port_direction;
			iopc_pkg::OFF_PORT_E: rd = port_e_i;
			iopc_pkg::OFF_DIR_E:  rd = fifth_port_direction;
			iopc_pkg::OFF_PULLUP: rd = pullup_en;
			iopc_pkg::OFF_CHG_EN: rd = change_en;
			iopc_pkg::OFF_CTRL:   rd = {3'h0, ctrl};
			iopc_pkg::OFF_STATUS: rd = {7'h00, status};
			iopc_pkg::OFF_MASK:   rd = {7'h00, mask};
			default:              rd = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Bus handshake, one registered ack per request, one cycle after it
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= {24'h00_0000, rd};
		end
	end

	// ------------------------------------------------------------
	// Port A open-drain latch
	// ------------------------------------------------------------
	// Only bits 2 and 3 are stored; the other bits of a write drop away
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			od_latch <= iopc_pkg::RST_OD_LATCH;
		end else if (wr_port_a) begin
			od_latch <= wd[3:2];
		end
	end

	// ------------------------------------------------------------
	// Port B to E latches and directions
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			second_port_latch     <= iopc_pkg::RST_LATCH;
			second_port_direction <= iopc_pkg::RST_DIR;
			third_port_latch      <= iopc_pkg::RST_LATCH;
			third_port_direction  <= iopc_pkg::RST_DIR;
			fourth_port_latch     <= iopc_pkg::RST_LATCH;
			fourth_port_direction <= iopc_pkg::RST_DIR;
			fifth_port_latch      <= iopc_pkg::RST_LATCH;
			fifth_port_direction  <= iopc_pkg::RST_DIR;
		end else begin
			// Takeover leaves direction bits as written; software
			// rewrites them once the peripheral is off
			if (wr_port_b) second_port_latch <= wd;
			if (wr_dir_b) second_port_direction <= wd;
			if (wr_port_c) third_port_latch <= wd;
			if (wr_dir_c) third_port_direction <= wd;
			if (wr_port_d) fourth_port_latch <= wd;
			if (wr_dir_d) fourth_port_direction <= wd;
			if (wr_port_e) fifth_port_latch <= wd;
			if (wr_dir_e) fifth_port_direction <= wd;
		end
	end

	// ------------------------------------------------------------
	// Control, pull-up and change-enable registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl      <= iopc_pkg::RST_CTRL;
			pullup_en <= 8'h00;
			change_en <= 8'h00;
			mask      <= 1'b0;
		end else begin
			if (wr_ctrl) ctrl <= wd[iopc_pkg::CTRL_WIDTH-1:0];
			if (wr_pullup) pullup_en <= wd;
			if (wr_chg_en) change_en <= wd;
			if (wr_mask) mask <= wd[iopc_pkg::ST_WIDTH-1:0];
		end
	end

	// ------------------------------------------------------------
	// Change detect and interrupt
	// ------------------------------------------------------------
	// Reference follows the pins so each change flags once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			change_ref <= 8'h00;
			status     <= 1'b0;
			irq_o      <= 1'b0;
		end else begin
			change_ref <= port_b_i;
			status     <= next_status;
			irq_o      <= |(next_status & mask);
		end
	end

	// ------------------------------------------------------------
	// Registered pin drive
	// ------------------------------------------------------------
	// Pins move one edge after the bus write, free of decode glitches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_a_o            <= 6'h00;
			port_a_oe_o         <= 6'h00;
			port_b_o            <= 8'h00;
			port_b_oe_o         <= 8'h00;
			port_b_pullup_o     <= 8'h00;
			port_c_o            <= 8'h00;
			port_c_oe_o         <= 8'h00;
			port_d_o            <= 8'h00;
			port_d_oe_o         <= 8'h00;
			port_e_o            <= 8'h00;
			port_e_oe_o         <= 8'h00;
			sys_bus_mode_o      <= 1'b0;
		end else begin
			// Open drain drives only low; serial unit owns pins 4 and 5
			port_a_o    <= {ser_b_out_i, ser_a_out_i, 4'h0};
			port_a_oe_o <= {ser_on & ser_b_oe_i, ser_on & ser_a_oe_i,
			                ~od_latch, 2'h0};
			port_b_o        <= next_b_out;
			port_b_oe_o     <= next_b_oe;
			port_b_pullup_o <= pullup_en & ~next_b_oe;
			port_c_o    <= c_out;
			port_c_oe_o <= c_oe;
			port_d_o    <= d_out;
			port_d_oe_o <= d_oe;
			port_e_o    <= e_out;
			port_e_oe_o <= e_oe;
			sys_bus_mode_o <= bus_mode;
		end
	end

	// ------------------------------------------------------------
	// Peripheral inputs taken from the resolved pin levels
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer0_clock_pin_o  <= 1'b0;
			capture1_o          <= 1'b0;
			capture2_o          <= 1'b0;
			timer12_clock_pin_o <= 1'b0;
			timer3_clock_pin_o  <= 1'b0;
			serial_in_o         <= 2'h0;
		end else begin
			timer0_clock_pin_o  <= a_level[1];
			capture1_o          <= b_level[0];
			capture2_o          <= b_level[1];
			timer12_clock_pin_o <= b_level[4];
			timer3_clock_pin_o  <= b_level[5];
			serial_in_o         <= a_level[5:4];
		end
	end

endmodule : iopc_top

// *** verif/iopc_top_props.sv ***
// Concurrent checks on the port block's bus, interrupt and pin outputs
`timescale 1ns/1ps
module iopc_props (
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Register bus and interrupt
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       irq_o,
	// Pins and peripheral side
	input wire logic [5:0] port_a_o,
	input wire logic [5:0] port_a_oe_o,
	input wire logic [7:0] port_b_i,
	input wire logic [7:0] port_b_oe_o,
	input wire logic [7:0] port_b_pullup_o,
	input wire logic [7:0] port_c_oe_o,
	input wire logic       sys_bus_mode_o,
	input wire logic [7:0] bus_c_oe_i,
	input wire logic       ser_a_out_i,
	input wire logic       ser_a_oe_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
		|=> wb_ack_o) else $error("request not acked next cycle");
	a_od_drive_low: assert property (port_a_oe_o[3:2] != 2'h0 |->
		(port_a_o[3:2] & port_a_oe_o[3:2]) == 2'h0)
		else $error("open drain pin driven high");
	a_a_low_idle: assert property (port_a_oe_o[1:0] == 2'h0)
		else $error("port A pin 0 or 1 driven");
	a_bus_copy: assert property (sys_bus_mode_o |->
		port_c_oe_o == $past(bus_c_oe_i))
		else $error("port C enable not from system bus");
	a_pullup_input: assert property (
		(port_b_pullup_o & port_b_oe_o) == 8'h00)
		else $error("pull-up on a driven pin");
	a_ser_pass: assert property (port_a_oe_o[4] |-> $past(ser_a_oe_i) &&
		port_a_o[4] == $past(ser_a_out_i))
		else $error("serial pin not from serial unit");
	// Irq rise without bus traffic needs a recent pin change as cause
	a_irq_cause: assert property ($rose(irq_o) && !$past(wb_cyc_i) &&
		!$past(wb_cyc_i, 2) |-> $past(port_b_i) != $past(port_b_i, 2) ||
		$past(port_b_i, 2) != $past(port_b_i, 3))
		else $error("interrupt rose with no cause");
	// Main scenarios reached
	c_ack: cover property (wb_ack_o);
	c_irq: cover property ($rose(irq_o));
	c_gpio: cover property ($fell(sys_bus_mode_o));
	c_ser: cover property (port_a_oe_o[4]);
endmodule : iopc_props

bind iopc_top iopc_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .irq_o, .port_a_o, .port_a_oe_o, .port_b_i, .port_b_oe_o,
	.port_b_pullup_o, .port_c_oe_o, .sys_bus_mode_o, .bus_c_oe_i,
	.ser_a_out_i, .ser_a_oe_i);

// *** verif/iopc_pins.sv ***
// Model of the external circuitry that resolves pin levels
`timescale 1ns/1ps
module iopc_pins (
	// Block side
	input  wire logic [5:0] a_drv_i,
	input  wire logic [5:0] a_oe_i,
	input  wire logic [7:0] b_drv_i,
	input  wire logic [7:0] b_oe_i,
	input  wire logic [7:0] b_pu_i,
	input  wire logic [7:0] c_drv_i,
	input  wire logic [7:0] c_oe_i,
	// Outside drivers
	input  wire logic [5:0] a_ext_i,
	input  wire logic [7:0] b_ext_i,
	input  wire logic [7:0] b_ext_en_i,
	input  wire logic [7:0] c_ext_i,
	// Resolved levels
	output logic      [5:0] a_pin_o,
	output logic      [7:0] b_pin_o,
	output logic      [7:0] c_pin_o
);
	// Open drain pins float up through the board pull-up
	assign a_pin_o[1:0] = a_ext_i[1:0];
	assign a_pin_o[3:2] = (a_oe_i[3:2] & a_drv_i[3:2]) | ~a_oe_i[3:2];
	assign a_pin_o[5:4] = (a_oe_i[5:4] & a_drv_i[5:4]) |
		(~a_oe_i[5:4] & a_ext_i[5:4]);
	// Undriven, unpulled pins show a moving level, never a stale one
	assign b_pin_o = (b_oe_i & b_drv_i) | (~b_oe_i & b_ext_en_i & b_ext_i) |
		(~b_oe_i & ~b_ext_en_i & (b_pu_i | ~b_ext_i));
	assign c_pin_o = (c_oe_i & c_drv_i) | (~c_oe_i & c_ext_i);
endmodule : iopc_pins

// *** verif/tb_iopc_top.sv ***
// Self-checking bench for the port pin control block
`timescale 1ns/1ps
module tb_iopc_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, irq_o, wb_ack_o;
	logic        pwm1, pwm2, sa_out, sa_oe, sys_bus_mode_o;
	logic        capture1_o, capture2_o, timer0_clock_pin_o;
	logic        timer12_clock_pin_o, timer3_clock_pin_o;
	logic [1:0]  serial_in_o;
	logic [3:0]  wb_sel;
	logic [5:0]  ext_a, a_o, a_oe, a_pin;
	logic [7:0]  wb_adr, rd_q, ext_b, ext_b_en, ext_c, bc_oe;
	logic [7:0]  port_b_o, port_b_oe_o, b_pu, b_pin, c_o, port_c_oe_o, c_pin;
	logic [7:0]  port_e_oe_o;
	logic [31:0] wb_dat, wb_dat_o;
	int          err_total, n_compared;

	iopc_top dut (.clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
		.wb_sel_i(wb_sel), .wb_dat_o, .wb_ack_o, .irq_o, .port_a_i(a_pin),
		.port_a_o(a_o), .port_a_oe_o(a_oe), .port_b_i(b_pin), .port_b_o,
		.port_b_oe_o, .port_b_pullup_o(b_pu), .port_c_i(c_pin),
		.port_c_o(c_o), .port_c_oe_o, .port_d_i(8'h00), .port_d_o(),
		.port_d_oe_o(), .port_e_i(8'h00), .port_e_o(), .port_e_oe_o,
		.sys_bus_mode_o, .bus_c_out_i(8'h3c), .bus_c_oe_i(bc_oe),
		.bus_d_out_i(ext_c), .bus_d_oe_i(bc_oe), .bus_e_out_i(ext_b),
		.bus_e_oe_i(bc_oe), .pwm1_i(pwm1), .pwm2_i(pwm2),
		.ser_a_out_i(sa_out), .ser_a_oe_i(sa_oe), .ser_b_out_i(sa_out),
		.ser_b_oe_i(sa_oe), .timer0_clock_pin_o, .capture1_o, .capture2_o,
		.timer12_clock_pin_o, .timer3_clock_pin_o, .serial_in_o);
	iopc_pins pins (.a_drv_i(a_o), .a_oe_i(a_oe), .b_drv_i(port_b_o),
		.b_oe_i(port_b_oe_o), .b_pu_i(b_pu), .c_drv_i(c_o),
		.c_oe_i(port_c_oe_o), .a_ext_i(ext_a), .b_ext_i(ext_b),
		.b_ext_en_i(ext_b_en), .c_ext_i(ext_c), .a_pin_o(a_pin),
		.b_pin_o(b_pin), .c_pin_o(c_pin));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One classic cycle; data is taken only at the edge that shows ack
	task automatic xfer(input logic we, input logic [7:0] a, d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd_q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (n >= 20) begin
			chk("ack", 8'h01, 8'h00);
			conclude();
		end
		@(posedge clk_i);
	endtask : xfer
	task automatic wr(input logic [7:0] a, d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, e, input string nm);
		xfer(1'b0, a, 8'h00);
		chk(nm, e, rd_q);
	endtask : rdc

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rdc(iopc_pkg::OFF_DIR_B, 8'hff, "dir_b");
		chk("bus_mode", 8'h01, {7'h00, sys_bus_mode_o});
		rdc(iopc_pkg::OFF_PORT_A, 8'h2e, "port_a");
		wr(8'h3c, 8'h55);
		rdc(8'h3c, 8'h00, "unmapped");
		wb_sel <= 4'h0;
		wr(iopc_pkg::OFF_DIR_B, 8'h00);
		wb_sel <= 4'hf;
		rdc(iopc_pkg::OFF_DIR_B, 8'hff, "dir_sel");
		$display("test reset done");
	endtask : t_reset
	task automatic t_dir_b();
		wr(iopc_pkg::OFF_PORT_B, 8'h35);
		wr(iopc_pkg::OFF_DIR_B, 8'hcf);
		chk("b_oe", 8'h30, port_b_oe_o);
		chk("b_out", 8'h30, port_b_o & 8'h30);
		rdc(iopc_pkg::OFF_PORT_B, (ext_b & 8'hcf) | 8'h30, "b_pins");
		chk("b_alt", 8'h0e, {4'h0, timer3_clock_pin_o, timer12_clock_pin_o,
			capture2_o, capture1_o});
		$display("test direction done");
	endtask : t_dir_b
	task automatic t_port_a();
		wr(iopc_pkg::OFF_PORT_A, 8'hf3);
		chk("a_oe", 8'h0c, {2'b00, a_oe});
		chk("a_out", 8'h00, {2'b00, a_o & 6'h0c});
		rdc(iopc_pkg::OFF_PORT_A, 8'h22, "a_pins");
		chk("t0_clk", 8'h01, {7'h00, timer0_clock_pin_o});
		wr(iopc_pkg::OFF_PORT_A, 8'h0c);
		chk("a_free", 8'h00, {2'b00, a_oe});
		rdc(iopc_pkg::OFF_PORT_A, 8'h2e, "a_release");
		$display("test port A done");
	endtask : t_port_a
	task automatic t_periph();
		pwm1 <= 1'b1;
		sa_oe <= 1'b1;
		wr(iopc_pkg::OFF_CTRL, 8'h1e);
		chk("pwm_oe", 8'h0c, port_b_oe_o & 8'h0c);
		chk("pwm_out", 8'h04, port_b_o & 8'h0c);
		chk("ser_oe", 8'h30, {2'b00, a_oe & 6'h30});
		// Serial inputs sit one register behind the pin drive
		@(posedge clk_i);
		chk("ser_in", 8'h03, {6'h00, serial_in_o});
		rdc(iopc_pkg::OFF_DIR_B, 8'hcf, "dir_kept");
		wr(iopc_pkg::OFF_CTRL, 8'h02);
		chk("pwm_off", 8'h00, port_b_oe_o & 8'h0c);
		chk("gpio", 8'h00, {7'h00, sys_bus_mode_o});
		$display("test peripherals done");
	endtask : t_periph
	task automatic t_modes();
		int m;
		wr(iopc_pkg::OFF_DIR_C, 8'h0f);
		for (m = 0; m < 4; m++) begin
			wr(iopc_pkg::OFF_CTRL, m[7:0]);
			chk("mode", (m < 2) ? 8'h01 : 8'h00, {7'h00, sys_bus_mode_o});
			chk("c_oe", (m < 2) ? 8'h5a : 8'hf0, port_c_oe_o);
			chk("c_out", (m < 2) ? 8'h3c : 8'h00, c_o);
			chk("e_oe", (m < 2) ? 8'h5a : 8'h00, port_e_oe_o);
		end
		rdc(iopc_pkg::OFF_PORT_C, ext_c & 8'h0f, "c_pins");
		$display("test modes done");
	endtask : t_modes
	task automatic t_change();
		int n;
		wr(iopc_pkg::OFF_PULLUP, 8'hff);
		chk("pullup", 8'hcf, b_pu);
		wr(iopc_pkg::OFF_CHG_EN, 8'hff);
		wr(iopc_pkg::OFF_MASK, 8'h01);
		ext_b <= ext_b ^ 8'h01;
		for (n = 0; n < 10 && irq_o !== 1'b1; n++)
			@(posedge clk_i);
		chk("irq", 8'h01, {7'h00, irq_o});
		if (irq_o !== 1'b1)
			conclude();
		rdc(iopc_pkg::OFF_STATUS, 8'h01, "status");
		wr(iopc_pkg::OFF_STATUS, 8'h01);
		chk("irq_clr", 8'h00, {7'h00, irq_o});
		ext_b <= ext_b ^ 8'h10;
		repeat (4) @(posedge clk_i);
		rdc(iopc_pkg::OFF_STATUS, 8'h00, "out_pin");
		wr(iopc_pkg::OFF_MASK, 8'h00);
		ext_b <= ext_b ^ 8'h80;
		repeat (4) @(posedge clk_i);
		chk("masked", 8'h00, {7'h00, irq_o});
		rdc(iopc_pkg::OFF_STATUS, 8'h01, "sticky");
		$display("test change done");
	endtask : t_change

	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, wb_sel, ext_b_en} = {1'b1, 4'hf, 8'hff};
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
		{pwm1, pwm2, sa_out, sa_oe} = 4'h2;
		{ext_a, ext_b, ext_c, bc_oe} = {6'h2a, 8'ha6, 8'h96, 8'h5a};
		err_total = 0;
		n_compared = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_dir_b();
		t_port_a();
		t_periph();
		t_modes();
		t_change();
		conclude();
	end
endmodule : tb_iopc_top
